// ### rtl/reo_regs.sv
// reo_regs: apb register bank that forces rails on or kills them, and holds
// the open-drain general output level.
// assumes: apb master on pclk; sequencer enables come from pclk logic;
// enable pins are asynchronous and synchronised here.
//
// Overview of operation
// - Second and third ldo follow the ldo-switch pin when their bit is clear, and turn on whatever the pin when set.
// - Switch A is on when either pin is high if its bit is clear, and on regardless of both pins when set, unless kill bit 5 is zero.
// - Force-on bits 5, 4 and 3 hold bucks six, five and four on irrespective of the sequencer.
// - Force-on bits 2, 1 and 0 hold bucks three, two and one on unless that buck's kill bit is zero.
// - Kill bit 6 of the kill/force register turns switch B off when zero whatever the sequencer requests.
// - Kill bit 5 turns switch A off when zero and beats switch A's force-on bit.
// - Kill bit 4 turns the termination ldo off when zero; its reset value depends on the variant.
// - Bit 3 forces the termination ldo on unless its kill bit is zero, else it follows sequencing.
// - Bit 1 forces switch B on unless its kill bit is zero, else it follows sequencing.
// - The force-on register sits at 9Eh and resets to all zero.
// - The kill/force register sits at 9Fh with switch kills reset to one and a variant term ldo pair.
// - Bit 5 of the register at A1h holds the open-drain output level and the register resets to 20h.
// - Bits 2 to 0 of the buck control register are active-low buck kills that reset to one.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
module reo_regs
  import reo_pkg::*;
#(
  parameter bit TERM_VARIANT_B = 1'b0
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [REO_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  ldo_switch_enable_pin,
  input  wire logic                  switch_a_enable_pin,
  input  wire logic                  chip_enable_pin,
  input  wire logic [1:0]            sleep_state_pins,
  input  wire logic [5:0]            seq_buck_en,
  input  wire logic                  seq_switch_b_en,
  input  wire logic                  seq_term_ldo_en,
  output logic      [REO_NUM_RAILS-1:0] rail_enable,
  output logic      [2:0]            buck_mode,
  output logic                       gpo_out,
  output logic                       gpo_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode helper, used for both the write and the read path
  function automatic logic hit(input logic [REO_ADDR_W-1:0] a,
                               input logic [11:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic [7:0] force_on_q;
  logic [7:0] force_on_d;
  logic [7:0] kill_force_q;
  logic [7:0] kill_force_d;
  logic [7:0] gen_output_q;
  logic [7:0] gen_output_d;
  logic [7:0] buck_ctrl_q;
  logic [7:0] buck_ctrl_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;

  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [7:0]  rd_byte;

  // variant choice is a strap-like constant, so it is safe at reset
  localparam logic [7:0] KILL_FORCE_RST = TERM_VARIANT_B
                                        ? REO_RST_KILL_FORCE_B
                                        : REO_RST_KILL_FORCE_A;

  // pin inputs, synchronised before any logic reads them
  logic [4:0]  pins_async;
  logic [4:0]  pins_sync;
  logic        ldo_sw_pin_s;
  logic        sw_a_pin_s;
  logic        chip_en_s;
  logic [1:0]  sleep_s;

  logic [REO_NUM_RAILS-1:0] rail_kill_n;
  logic [REO_NUM_RAILS-1:0] rail_force;
  logic [REO_NUM_RAILS-1:0] rail_normal;

  ////////////////////////////////////////////////////////////////////////////
  // apb access: zero wait states, pslverr on an unmapped address
  assign access = psel & penable;
  assign wr_en  = access & pwrite & pstrb[0];
  assign mapped = hit(paddr, REO_IDX_BUCK_CONTROL)
                | hit(paddr, REO_IDX_RAIL_FORCE_ON)
                | hit(paddr, REO_IDX_RAIL_KILL_FORCE)
                | hit(paddr, REO_IDX_GENERAL_OUTPUT)
                | hit(paddr, REO_IDX_RAIL_STATUS);
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // register next values; only byte lane 0 carries data
  always_comb
  begin
    force_on_d   = force_on_q;
    kill_force_d = kill_force_q;
    gen_output_d = gen_output_q;
    buck_ctrl_d  = buck_ctrl_q;
    if (wr_en)
    begin
      if (hit(paddr, REO_IDX_RAIL_FORCE_ON))
        force_on_d = pwdata[7:0];
      else if (hit(paddr, REO_IDX_RAIL_KILL_FORCE))
        kill_force_d = pwdata[7:0];
      else if (hit(paddr, REO_IDX_GENERAL_OUTPUT))
        gen_output_d = pwdata[7:0];
      else if (hit(paddr, REO_IDX_BUCK_CONTROL))
        buck_ctrl_d = pwdata[7:0] & REO_BUCK_CONTROL_RW;
    end
  end

  // reset to a constant per variant: the parameter never changes at run time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      force_on_q   <= REO_RST_FORCE_ON;
      kill_force_q <= KILL_FORCE_RST;
      gen_output_q <= REO_RST_GEN_OUTPUT;
      buck_ctrl_q  <= REO_RST_BUCK_CONTROL;
    end
    else
    begin
      force_on_q   <= force_on_d;
      kill_force_q <= kill_force_d;
      gen_output_q <= gen_output_d;
      buck_ctrl_q  <= buck_ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and error; read data registered so it stands in the access
  // phase that follows the setup cycle
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(paddr, REO_IDX_RAIL_FORCE_ON))
      rd_byte = force_on_q;
    else if (hit(paddr, REO_IDX_RAIL_KILL_FORCE))
      rd_byte = kill_force_q;
    else if (hit(paddr, REO_IDX_GENERAL_OUTPUT))
      rd_byte = gen_output_q;
    else if (hit(paddr, REO_IDX_BUCK_CONTROL))
      rd_byte = buck_ctrl_q;
    else if (hit(paddr, REO_IDX_RAIL_STATUS))
      rd_byte = rail_enable[7:0];
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel & ~penable)
    begin
      prdata_d  = {24'h000000, rd_byte};
      pslverr_d = ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & access;

  ////////////////////////////////////////////////////////////////////////////
  // enable pins cross into pclk before use
  assign pins_async = {sleep_state_pins, chip_enable_pin,
                       switch_a_enable_pin, ldo_switch_enable_pin};

  reo_pin_sync #(
    .WIDTH    (5)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  assign ldo_sw_pin_s = pins_sync[0];
  assign sw_a_pin_s   = pins_sync[1];
  assign chip_en_s    = pins_sync[2];
  assign sleep_s      = pins_sync[4:3];

  ////////////////////////////////////////////////////////////////////////////
  // per-rail kill, force and normal terms
  always_comb
  begin
    rail_kill_n = '1;
    rail_force  = '0;
    rail_normal = '0;
    // bucks one to three: force-on beaten by the buck control kills
    rail_force[REO_RAIL_BUCK_ONE]   = force_on_q[REO_FO_BUCK_ONE];
    rail_force[REO_RAIL_BUCK_TWO]   = force_on_q[REO_FO_BUCK_TWO];
    rail_force[REO_RAIL_BUCK_THREE] = force_on_q[REO_FO_BUCK_THREE];
    rail_kill_n[REO_RAIL_BUCK_ONE]  = buck_ctrl_q[REO_BC_KILL_LSB];
    rail_kill_n[REO_RAIL_BUCK_TWO]  = buck_ctrl_q[REO_BC_KILL_LSB+1];
    rail_kill_n[REO_RAIL_BUCK_THREE] = buck_ctrl_q[REO_BC_KILL_LSB+2];
    // bucks four to six: force-on only
    rail_force[REO_RAIL_BUCK_FOUR] = force_on_q[REO_FO_BUCK_FOUR];
    rail_force[REO_RAIL_BUCK_FIVE] = force_on_q[REO_FO_BUCK_FIVE];
    rail_force[REO_RAIL_BUCK_SIX]  = force_on_q[REO_FO_BUCK_SIX];
    rail_normal[5:0] = seq_buck_en;
    // ldo two and three follow the ldo-switch pin
    rail_force[REO_RAIL_LDO_TWO]   = force_on_q[REO_FO_LDO_TWO];
    rail_force[REO_RAIL_LDO_THREE] = kill_force_q[REO_KF_LDO_THREE];
    rail_normal[REO_RAIL_LDO_TWO]   = ldo_sw_pin_s;
    rail_normal[REO_RAIL_LDO_THREE] = ldo_sw_pin_s;
    // switch a: either pin, force-on, kill
    rail_force[REO_RAIL_SWITCH_A]  = force_on_q[REO_FO_SWITCH_A];
    rail_normal[REO_RAIL_SWITCH_A] = ldo_sw_pin_s | sw_a_pin_s;
    rail_kill_n[REO_RAIL_SWITCH_A] = kill_force_q[REO_KF_SWITCH_A_KILL];
    // switch b and termination ldo: sequencer request, force, kill
    rail_force[REO_RAIL_SWITCH_B]  = kill_force_q[REO_KF_SWITCH_B_FORCE];
    rail_normal[REO_RAIL_SWITCH_B] = seq_switch_b_en;
    rail_kill_n[REO_RAIL_SWITCH_B] = kill_force_q[REO_KF_SWITCH_B_KILL];
    rail_force[REO_RAIL_TERM_LDO]  = kill_force_q[REO_KF_TERM_FORCE];
    rail_normal[REO_RAIL_TERM_LDO] = seq_term_ldo_en;
    rail_kill_n[REO_RAIL_TERM_LDO] = kill_force_q[REO_KF_TERM_KILL];
  end

  // chip enable and sleep pins reach the rails only through the sequencer
  // inputs; they are synchronised here but feed only unused_pins
  logic unused_pins;
  assign unused_pins = chip_en_s ^ sleep_s[0] ^ sleep_s[1];

  reo_rail_gate #(
    .RAILS     (REO_NUM_RAILS)
  ) u_rail_gate (
    .pclk      (pclk),
    .presetn   (presetn),
    .kill_n    (rail_kill_n),
    .force_on  (rail_force),
    .normal_en (rail_normal),
    .rail_en   (rail_enable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // open-drain output: zero pulls low, one releases
  assign gpo_out   = 1'b0;
  assign gpo_oe    = ~gen_output_q[REO_GO_LEVEL];
  assign buck_mode = buck_ctrl_q[5:3];

endmodule

// ### rtl/reo_pkg.sv
// reo_pkg: register map, field positions and reset values for the rail
// enable override bank.
// assumes: imported by reo_regs, its checker and the testbench; apb data is 32 bits wide.
package reo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // apb byte addresses: offsets are not all multiples of four, so each printed
  // offset is kept as an index and the byte address is four times it
  localparam logic [11:0] REO_IDX_BUCK_CONTROL   = 12'h09C;
  localparam logic [11:0] REO_IDX_RAIL_FORCE_ON  = 12'h09E;
  localparam logic [11:0] REO_IDX_RAIL_KILL_FORCE = 12'h09F;
  localparam logic [11:0] REO_IDX_GENERAL_OUTPUT = 12'h0A1;
  localparam logic [11:0] REO_IDX_RAIL_STATUS    = 12'h0B0;
  localparam int          REO_ADDR_W             = 14;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] REO_RST_FORCE_ON    = 8'h00;
  localparam logic [7:0] REO_RST_GEN_OUTPUT  = 8'h20;
  // kill/force reset: switch kills one, term ldo pair per factory variant
  localparam logic [7:0] REO_RST_KILL_FORCE_A = 8'h68;
  localparam logic [7:0] REO_RST_KILL_FORCE_B = 8'h70;
  // buck control: kills one, mode bits zero
  localparam logic [7:0] REO_RST_BUCK_CONTROL = 8'h07;
  localparam logic [7:0] REO_BUCK_CONTROL_RW  = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int REO_FO_LDO_TWO    = 7;
  localparam int REO_FO_SWITCH_A   = 6;
  localparam int REO_FO_BUCK_SIX   = 5;
  localparam int REO_FO_BUCK_FIVE  = 4;
  localparam int REO_FO_BUCK_FOUR  = 3;
  localparam int REO_FO_BUCK_THREE = 2;
  localparam int REO_FO_BUCK_TWO   = 1;
  localparam int REO_FO_BUCK_ONE   = 0;

  localparam int REO_KF_SWITCH_B_KILL = 6;
  localparam int REO_KF_SWITCH_A_KILL = 5;
  localparam int REO_KF_TERM_KILL     = 4;
  localparam int REO_KF_TERM_FORCE    = 3;
  localparam int REO_KF_SWITCH_B_FORCE = 1;
  localparam int REO_KF_LDO_THREE     = 0;

  localparam int REO_GO_LEVEL      = 5;
  localparam int REO_BC_KILL_LSB   = 0;

  // rail index order of the rail status vector and the rail enable outputs
  localparam int REO_NUM_RAILS = 11;
  typedef enum logic [3:0] {
    REO_RAIL_BUCK_ONE   = 4'h0,
    REO_RAIL_BUCK_TWO   = 4'h1,
    REO_RAIL_BUCK_THREE = 4'h2,
    REO_RAIL_BUCK_FOUR  = 4'h3,
    REO_RAIL_BUCK_FIVE  = 4'h4,
    REO_RAIL_BUCK_SIX   = 4'h5,
    REO_RAIL_SWITCH_A   = 4'h6,
    REO_RAIL_LDO_TWO    = 4'h7,
    REO_RAIL_LDO_THREE  = 4'h8,
    REO_RAIL_SWITCH_B   = 4'h9,
    REO_RAIL_TERM_LDO   = 4'hA
  } reo_rail_type;

endpackage

// ### rtl/reo_pin_sync.sv
// reo_pin_sync: two-flop synchroniser for a vector of pin levels.
// assumes: inputs are asynchronous levels; output is read only as a level.
`timescale 1ns/100ps
module reo_pin_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ### rtl/reo_rail_gate.sv
// reo_rail_gate: effective enable of a group of rails from kill, force-on
// and normal request terms, registered per rail.
// assumes: all inputs are already in the pclk domain.
`timescale 1ns/100ps
module reo_rail_gate
#(
  parameter int RAILS = 11
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [RAILS-1:0] kill_n,
  input  wire logic [RAILS-1:0] force_on,
  input  wire logic [RAILS-1:0] normal_en,
  output logic      [RAILS-1:0] rail_en
);

  logic [RAILS-1:0] rail_en_d;
  logic [RAILS-1:0] rail_en_q;

  // a zero kill always wins over force-on and the normal request
  genvar g;
  generate
    for (g = 0; g < RAILS; g++)
    begin : g_rail
      assign rail_en_d[g] = kill_n[g] & (force_on[g] | normal_en[g]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rail_en_q <= '0;
    else
      rail_en_q <= rail_en_d;
  end

  assign rail_en = rail_en_q;

endmodule

// ### verification/reo_regs_sva.sv
// reo_regs_sva: port assertions for the rail enable override bank.
// assumes: bound into reo_regs; registers are shadowed from apb writes.
`timescale 1ns/100ps
module reo_regs_sva
  import reo_pkg::*;
#(
  parameter bit TERM_VARIANT_B = 1'b0
)
(
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [REO_ADDR_W-1:0]    paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [3:0]               pstrb,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     ldo_switch_enable_pin,
  input wire logic [5:0]               seq_buck_en,
  input wire logic                     seq_switch_b_en,
  input wire logic                     seq_term_ldo_en,
  input wire logic [REO_NUM_RAILS-1:0] rail_enable,
  input wire logic                     gpo_out,
  input wire logic                     gpo_oe
);
  localparam logic [13:0] A_BC = {REO_IDX_BUCK_CONTROL, 2'b00};
  localparam logic [13:0] A_FO = {REO_IDX_RAIL_FORCE_ON, 2'b00};
  localparam logic [13:0] A_KF = {REO_IDX_RAIL_KILL_FORCE, 2'b00};
  localparam logic [13:0] A_GO = {REO_IDX_GENERAL_OUTPUT, 2'b00};
  localparam logic [13:0] A_ST = {REO_IDX_RAIL_STATUS, 2'b00};
  logic [7:0] fo_q, kf_q, go_q, bc_q, rd_exp;
  logic       mapped;

  // shadow registers; a write lands only with pstrb[0] in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fo_q <= REO_RST_FORCE_ON;
      kf_q <= TERM_VARIANT_B ? REO_RST_KILL_FORCE_B : REO_RST_KILL_FORCE_A;
      go_q <= REO_RST_GEN_OUTPUT;
      bc_q <= REO_RST_BUCK_CONTROL;
    end
    else if (psel && penable && pwrite && pstrb[0])
    begin
      case (paddr)
        A_FO: fo_q <= pwdata[7:0];
        A_KF: kf_q <= pwdata[7:0];
        A_GO: go_q <= pwdata[7:0];
        A_BC: bc_q <= pwdata[7:0] & REO_BUCK_CONTROL_RW;
        default: ;
      endcase
    end
  end

  // expected read data; the status word mirrors rails and is not modelled
  always_comb
  begin
    case (paddr)
      A_FO: rd_exp = fo_q;
      A_KF: rd_exp = kf_q;
      A_GO: rd_exp = go_q;
      A_BC: rd_exp = bc_q;
      default: rd_exp = 8'h00;
    endcase
  end
  assign mapped = (paddr inside {A_BC, A_FO, A_KF, A_GO, A_ST});

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_apb_write;
    psel && !penable ##1 psel && penable && pwrite && pstrb[0];
  endsequence
  // pins pass two sync flops before the rail flop
  sequence s_pin_held;
    ldo_switch_enable_pin [*3];
  endsequence

  a_pin_ldo_on: assert property (s_pin_held |=>
    rail_enable[8:7] == 2'b11)
    else $error("ldo rails not on with pin held high");
  a_buck_high_force: assert property ($past(presetn) |->
    rail_enable[5:3] == ($past(fo_q[5:3]) | $past(seq_buck_en[5:3])))
    else $error("bucks four to six wrong");
  a_buck_low_kill: assert property ($past(presetn) |->
    rail_enable[2:0] == ($past(bc_q[2:0])
      & ($past(fo_q[2:0]) | $past(seq_buck_en[2:0]))))
    else $error("bucks one to three wrong");
  a_switch_b_gate: assert property ($past(presetn) |->
    rail_enable[9] == ($past(kf_q[6])
      & ($past(kf_q[1]) | $past(seq_switch_b_en))))
    else $error("switch b enable wrong");
  a_term_ldo_gate: assert property ($past(presetn) |->
    rail_enable[10] == ($past(kf_q[4])
      & ($past(kf_q[3]) | $past(seq_term_ldo_en))))
    else $error("termination ldo enable wrong");
  a_switch_a_kill: assert property (!kf_q[5] |=> !rail_enable[6])
    else $error("switch a on while killed");
  a_switch_a_force: assert property (kf_q[5] && fo_q[6] |=>
    rail_enable[6])
    else $error("switch a off while forced");
  a_write_gpo: assert property
    (s_apb_write ##0 paddr == A_GO |=>
    gpo_oe == !$past(pwdata[5]) && !gpo_out)
    else $error("open drain pin does not follow level bit");
  a_read_data: assert property (psel && penable && !pwrite &&
    paddr != A_ST |-> prdata == {24'h000000, rd_exp} && pready)
    else $error("read data wrong");
  a_slave_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error wrong");
endmodule

bind reo_regs reo_regs_sva #(.TERM_VARIANT_B(TERM_VARIANT_B)) reo_regs_sva_inst
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ldo_switch_enable_pin(ldo_switch_enable_pin), .seq_buck_en(seq_buck_en),
  .seq_switch_b_en(seq_switch_b_en), .seq_term_ldo_en(seq_term_ldo_en),
  .rail_enable(rail_enable), .gpo_out(gpo_out), .gpo_oe(gpo_oe)
);

// ### verification/testbench.sv
// testbench: directed apb tests of the rail enable override bank.
// assumes: reo_regs and its checker compiled first; default variant.
`timescale 1ns/100ps
module testbench
  import reo_pkg::*;
;
  localparam logic [13:0] A_BC = 14'h0270;
  localparam logic [13:0] A_FO = 14'h0278;
  localparam logic [13:0] A_KF = 14'h027C;
  localparam logic [13:0] A_GO = 14'h0284;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd_q;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, err_q, gpo_out, gpo_oe;
  logic        ldo_pin = 1'b0, swa_pin = 1'b0, chip_pin = 1'b0;
  logic [1:0]  sleep_pins = 2'b00;
  logic [5:0]  seq_buck_en = 6'h00;
  logic        seq_switch_b_en = 1'b0, seq_term_ldo_en = 1'b0;
  logic [10:0] rail_enable;
  logic [2:0]  buck_mode;
  int          errors = 0, comparisons = 0;

  reo_regs reo_regs_inst
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ldo_switch_enable_pin(ldo_pin), .switch_a_enable_pin(swa_pin),
    .chip_enable_pin(chip_pin), .sleep_state_pins(sleep_pins),
    .seq_buck_en(seq_buck_en), .seq_switch_b_en(seq_switch_b_en),
    .seq_term_ldo_en(seq_term_ldo_en), .rail_enable(rail_enable),
    .buck_mode(buck_mode), .gpo_out(gpo_out), .gpo_oe(gpo_oe)
  );

  // free running 50 MHz clock
  always #10 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; waits for pready so wait states would be honoured
  task automatic xfer(input logic wr, input logic [13:0] a,
    input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    pstrb   <= s;
    do
    begin
      @(posedge pclk);
      penable <= 1'b1;
      n++;
    end
    while (!(penable === 1'b1 && pready === 1'b1) && n < 20);
    if (n >= 20)
      errors++;
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [13:0] a);
    xfer(1'b0, a, 8'h00, 4'h0);
  endtask

  // sample on falling edges so registered outputs have settled
  task automatic settle(input int k);
    repeat (k) @(negedge pclk);
  endtask

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd(A_FO);
    check("force on reset", rd_q, 32'h00);
    rd(A_KF);
    check("kill force reset", rd_q, 32'h68);
    rd(A_GO);
    check("output reset", rd_q, 32'h20);
    rd(A_BC);
    check("buck control reset", rd_q, 32'h07);
    settle(1);
    check("rails idle", 32'(rail_enable), 32'h0);
    check("pin released", 32'({gpo_out, gpo_oe}), 32'h0);
    $display("test_reset done");
  endtask

  // each force bit alone; term ldo stays killed by its reset value
  task automatic test_force_walk();
    for (int i = 0; i < 8; i++)
    begin
      wr(A_FO, 8'(1 << i));
      settle(2);
      check("forced rail", 32'(rail_enable), 32'(1 << i));
      rd(A_FO);
      check("force readback", rd_q, 32'(1 << i));
    end
    wr(A_FO, 8'h00);
    $display("test_force_walk done");
  endtask

  task automatic test_buck_kill();
    @(posedge pclk);
    seq_buck_en <= 6'h38;
    wr(A_FO, 8'h07);
    wr(A_BC, 8'hFD);
    settle(2);
    check("buck rails", 32'(rail_enable), 32'h03D);
    check("buck mode", 32'(buck_mode), 32'h7);
    rd(A_BC);
    check("buck control masked", rd_q, 32'h3D);
    wr(A_BC, 8'h07);
    wr(A_FO, 8'h00);
    seq_buck_en <= 6'h00;
    $display("test_buck_kill done");
  endtask

  // table of kill and force codes against sequencer requests
  task automatic test_kill_force();
    logic [7:0] kf [4] = '{8'h7B, 8'h0B, 8'h70, 8'h00};
    logic [1:0] sq [4] = '{2'b00, 2'b11, 2'b11, 2'b11};
    logic [3:0] ex [4] = '{4'hF, 4'h2, 4'hD, 4'h0};
    wr(A_FO, 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      {seq_term_ldo_en, seq_switch_b_en} <= sq[i];
      wr(A_KF, kf[i]);
      settle(2);
      check("switch and ldo rails", 32'({rail_enable[10:8], rail_enable[6]}),
        32'(ex[i]));
      rd(A_KF);
      check("kill force readback", rd_q, 32'(kf[i]));
    end
    @(posedge pclk);
    {seq_term_ldo_en, seq_switch_b_en} <= 2'b00;
    wr(A_KF, 8'h68);
    wr(A_FO, 8'h00);
    $display("test_kill_force done");
  endtask

  task automatic test_pins();
    @(posedge pclk);
    ldo_pin    <= 1'b1;
    chip_pin   <= 1'b1;
    sleep_pins <= 2'b11;
    settle(4);
    check("ldo pin rails", 32'(rail_enable), 32'h1C0);
    // the status word mirrors the low eight rail enables
    rd(14'h02C0);
    check("rail status", rd_q, 32'h0C0);
    @(posedge pclk);
    ldo_pin <= 1'b0;
    swa_pin <= 1'b1;
    settle(4);
    check("switch pin rail", 32'(rail_enable), 32'h040);
    wr(A_KF, 8'h48);
    settle(2);
    check("switch a killed", 32'(rail_enable), 32'h000);
    @(posedge pclk);
    swa_pin <= 1'b0;
    wr(A_KF, 8'h68);
    $display("test_pins done");
  endtask

  task automatic test_output_errors();
    wr(A_GO, 8'h00);
    settle(1);
    check("pin driven low", 32'({gpo_out, gpo_oe}), 32'h1);
    rd(A_GO);
    check("output readback", rd_q, 32'h00);
    wr(A_GO, 8'h20);
    settle(1);
    check("pin high impedance", 32'({gpo_out, gpo_oe}), 32'h0);
    xfer(1'b1, A_FO, 8'hFF, 4'h0);
    rd(A_FO);
    check("masked write ignored", rd_q, 32'h00);
    wr(14'h0280, 8'hFF);
    check("unmapped write error", 32'(err_q), 32'h1);
    rd(14'h0280);
    check("unmapped read", 32'({rd_q[7:0], err_q}), 32'h1);
    $display("test_output_errors done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence after a 20 cycle reset
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_force_walk();
    test_buck_kill();
    test_kill_force();
    test_pins();
    test_output_errors();
    print_verdict();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    errors++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
